/* File: hcec_pkg.sv */
// Command codes, error word layout and limits for the command checker
package hcec_pkg;
    localparam int CMD_W = 5;
    localparam int PAR_W = 8;
    localparam int ERRW_W = 8;
    localparam int CT_W = 2;
    // Command codes of the checker's own command port
    localparam logic [4:0] CMD_RECORD_FOR_RECOGNITION = 5'h00;
    localparam logic [4:0] CMD_RECORD = 5'h01;
    localparam logic [4:0] CMD_SAY_ONE_WORD = 5'h02;
    localparam logic [4:0] CMD_SAY_WORDS = 5'h03;
    localparam logic [4:0] CMD_SAY_SENTENCE = 5'h04;
    localparam logic [4:0] CMD_SAY_ARGUMENTED_SENTENCE = 5'h05;
    localparam logic [4:0] CMD_TUNE = 5'h06;
    localparam logic [4:0] CMD_SELECT_PROMPT_VOCABULARY = 5'h07;
    localparam logic [4:0] CMD_TOPIC_SAVE = 5'h08;
    localparam logic [4:0] CMD_TOPIC_DISABLE = 5'h09;
    localparam logic [4:0] CMD_TOPIC_ENABLE = 5'h0A;
    localparam logic [4:0] CMD_TOPIC_UNLOAD = 5'h0B;
    localparam logic [4:0] CMD_TOPIC_LOAD = 5'h0C;
    localparam logic [4:0] CMD_PLAY = 5'h0D;
    localparam logic [4:0] CMD_CURRENT_MESSAGE_TAG = 5'h0E;
    localparam logic [4:0] CMD_DELETE_MESSAGE = 5'h0F;
    localparam logic [4:0] CMD_DELETE_MESSAGES = 5'h10;
    localparam logic [4:0] CMD_GET_MESSAGE_LENGTH = 5'h11;
    localparam logic [4:0] CMD_GET_MESSAGE_TYPE = 5'h12;
    localparam logic [4:0] CMD_MESSAGE_INFO_GET = 5'h13;
    localparam logic [4:0] CMD_MESSAGE_INFO_SET = 5'h14;
    localparam logic [4:0] CMD_SET_DATE = 5'h15;
    localparam logic [4:0] CMD_GET_TIME_DATE = 5'h16;
    localparam logic [4:0] CMD_PHONEME_EXTRACTION = 5'h17;
    localparam logic [4:0] CMD_CHOOSE_ACTIVE_VOCABULARY = 5'h18;
    localparam logic [4:0] CMD_SELECT_MESSAGE = 5'h19;
    localparam logic [4:0] CMD_READ_ERROR_WORD = 5'h1A;
    // Error word bits
    localparam int PARAMETER_ERROR_FLAG_BIT = 3;
    localparam int ERR_INVALID_BIT = 7;
    // Limits
    localparam logic [7:0] COMPRESSION_MAX = 8'h03;
    localparam logic [7:0] MAX_SENTENCE_LENGTH = 8'h14;
    localparam logic [7:0] TUNABLE_COUNT = 8'h56;
    localparam logic [7:0] VOCAB_TYPE_EXTERNAL = 8'h01;
    localparam logic [7:0] FIRST_VOCAB_NUMBER = 8'h01;
    localparam logic [7:0] MINUTE_MAX = 8'h3B;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] DAY_MIN = 8'h01;
    localparam logic [7:0] DAY_MAX = 8'h07;
    // Decompression selections
    localparam logic [1:0] DEC_4K7 = 2'h0;
    localparam logic [1:0] DEC_6K7 = 2'h1;
    localparam logic [1:0] DEC_8K7 = 2'h2;
    localparam logic [1:0] DEC_PCM = 2'h3;
endpackage

/* File: hcec_checker.sv */
// Host command validation: parameter and state errors, vocabulary selection
`timescale 1ns/1ps
`default_nettype none
module hcec_checker
    import hcec_pkg::*;
#(
    parameter int MAX_TOPICS = 16,
    parameter int VOCABS = 4
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_cmd_valid,
    input  wire logic [CMD_W-1:0]  i_cmd_code,
    input  wire logic [PAR_W-1:0]  i_param0,
    input  wire logic [PAR_W-1:0]  i_param1,
    input  wire logic [PAR_W-1:0]  i_param2,
    input  wire logic [PAR_W-1:0]  i_vocab_words,
    input  wire logic [PAR_W-1:0]  i_vocab_sentences,
    input  wire logic [CT_W-1:0]   i_vocab_compression,
    input  wire logic              i_event,
    output logic                   o_cmd_done,
    output logic [ERRW_W-1:0]      o_error_word,
    output logic [PAR_W-1:0]       o_active_vocab,
    output logic                   o_prompt_set,
    output logic [CT_W-1:0]        o_decompression,
    output logic                   o_host_attention_request_n
);
    logic [ERRW_W-1:0]     err_r;
    logic [MAX_TOPICS-1:0] loaded_r;
    logic                  cur_msg_r;
    logic                  date_set_r;
    logic                  rr_pending_r;
    logic                  prompt_r;
    logic [PAR_W-1:0]      vocab_r;
    logic [CT_W-1:0]       dec_r;
    logic                  done_r;
    logic [ERRW_W-1:0]     rd_word_r;
    logic                  attn_n_r;
    logic                  param_err;
    logic                  state_err;
    logic                  is_read;
    logic                  topic_cmd;
    logic                  topic_ok;
    logic                  synth_cmd;

    assign is_read = i_cmd_valid && (i_cmd_code == CMD_READ_ERROR_WORD);
    assign topic_cmd = (i_cmd_code >= CMD_TOPIC_SAVE) && (i_cmd_code <= CMD_TOPIC_LOAD);
    assign topic_ok = (32'(i_param0) < MAX_TOPICS);
    assign synth_cmd = (i_cmd_code >= CMD_SAY_ONE_WORD)
                    && (i_cmd_code <= CMD_SAY_ARGUMENTED_SENTENCE);

    always_comb begin
        param_err = 1'b0;
        unique case (i_cmd_code)
            CMD_RECORD_FOR_RECOGNITION, CMD_RECORD:
                param_err = (i_param0 > COMPRESSION_MAX);
            CMD_SAY_ONE_WORD:
                param_err = (i_param0 > i_vocab_words);
            CMD_SAY_WORDS:
                param_err = (i_param0 > MAX_SENTENCE_LENGTH)
                         || (i_param1 > i_vocab_words);
            CMD_SAY_SENTENCE, CMD_SAY_ARGUMENTED_SENTENCE:
                param_err = (i_param0 > i_vocab_sentences);
            CMD_TUNE:
                param_err = (i_param0 > TUNABLE_COUNT);
            CMD_SELECT_PROMPT_VOCABULARY:
                param_err = (i_param0 != VOCAB_TYPE_EXTERNAL)
                         || (i_param1 < FIRST_VOCAB_NUMBER);
            CMD_SET_DATE:
                param_err = (i_param0 > MINUTE_MAX) || (i_param1 > HOUR_MAX)
                         || (i_param2 < DAY_MIN) || (i_param2 > DAY_MAX);
            CMD_CHOOSE_ACTIVE_VOCABULARY:
                param_err = (i_param0 < FIRST_VOCAB_NUMBER)
                         || (32'(i_param0) > VOCABS);
            default:
                param_err = topic_cmd && (!topic_ok
                         || ((i_cmd_code != CMD_TOPIC_LOAD)
                             && !loaded_r[i_param0[$clog2(MAX_TOPICS)-1:0]]));
        endcase
    end

    always_comb begin
        state_err = 1'b0;
        if (rr_pending_r && i_cmd_code != CMD_PHONEME_EXTRACTION && !is_read)
            state_err = 1'b1;
        if (synth_cmd && !prompt_r)
            state_err = 1'b1;
        if ((i_cmd_code >= CMD_PLAY) && (i_cmd_code <= CMD_MESSAGE_INFO_SET)
            && (i_cmd_code != CMD_DELETE_MESSAGES) && !cur_msg_r)
            state_err = 1'b1;
        if (i_cmd_code == CMD_GET_TIME_DATE && !date_set_r)
            state_err = 1'b1;
    end

    // Error word: the clearing read wins; other commands add new errors
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            err_r <= 8'h00;
            rd_word_r <= 8'h00;
        end else if (i_cmd_valid) begin
            if (is_read) begin
                rd_word_r <= err_r;
                err_r <= 8'h00;
            end else begin
                err_r[PARAMETER_ERROR_FLAG_BIT] <= err_r[PARAMETER_ERROR_FLAG_BIT] | param_err;
                err_r[ERR_INVALID_BIT] <= err_r[ERR_INVALID_BIT] | state_err;
            end
        end
    end

    // Device state tracked from accepted commands; rr_pending_r follows every command but the error word read
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            loaded_r <= '0;
            cur_msg_r <= 1'b0;
            date_set_r <= 1'b0;
            rr_pending_r <= 1'b0;
        end else if (i_cmd_valid && !is_read) begin
            rr_pending_r <= (i_cmd_code == CMD_RECORD_FOR_RECOGNITION) && !param_err;
            if (!param_err && !state_err) begin
                if (i_cmd_code == CMD_TOPIC_LOAD)
                    loaded_r[i_param0[$clog2(MAX_TOPICS)-1:0]] <= 1'b1;
                if (i_cmd_code == CMD_TOPIC_UNLOAD)
                    loaded_r[i_param0[$clog2(MAX_TOPICS)-1:0]] <= 1'b0;
                if (i_cmd_code == CMD_SET_DATE)
                    date_set_r <= 1'b1;
                if (i_cmd_code == CMD_SELECT_MESSAGE)
                    cur_msg_r <= 1'b1;
                if (i_cmd_code == CMD_DELETE_MESSAGE || i_cmd_code == CMD_DELETE_MESSAGES)
                    cur_msg_r <= 1'b0;
            end
        end
    end

    // Vocabulary selection and decompression choice
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            prompt_r <= 1'b0;
            vocab_r <= 8'h00;
            dec_r <= DEC_4K7;
        end else if (i_cmd_valid && !param_err && !state_err) begin
            if (i_cmd_code == CMD_SELECT_PROMPT_VOCABULARY) begin
                prompt_r <= 1'b1;
                vocab_r <= i_param1;
            end
            if (i_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY) begin
                vocab_r <= i_param0;
                dec_r <= i_vocab_compression;
            end
        end
    end

    // Completion strobe and attention line
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            done_r <= 1'b0;
            attn_n_r <= 1'b1;
        end else begin
            done_r <= i_cmd_valid;
            if (i_event)
                attn_n_r <= 1'b0;
            else if (is_read)
                attn_n_r <= 1'b1;
        end
    end

    assign o_cmd_done = done_r;
    assign o_error_word = rd_word_r;
    assign o_active_vocab = vocab_r;
    assign o_prompt_set = prompt_r;
    assign o_decompression = dec_r;
    assign o_host_attention_request_n = attn_n_r;

    chk_param_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && !is_read && param_err) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("parameter error not flagged");
    chk_rr_sequence: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (rr_pending_r && i_cmd_valid && !is_read && i_cmd_code != CMD_PHONEME_EXTRACTION)
        |=> err_r[ERR_INVALID_BIT])
        else $error("record not followed by extraction went unflagged");
    chk_read_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_read |=> (err_r == 8'h00) && (rd_word_r == $past(err_r)))
        else $error("error read did not clear");
    chk_synth_no_prompt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && synth_cmd && !prompt_r) |=> err_r[ERR_INVALID_BIT])
        else $error("synthesis without prompt vocabulary accepted");
    chk_date_before_get: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_GET_TIME_DATE && !date_set_r) |=> err_r[ERR_INVALID_BIT])
        else $error("time read before date set not flagged");
    chk_decomp_pick: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY && !param_err && !state_err)
        |=> (dec_r == $past(i_vocab_compression)))
        else $error("decompression not matched to vocabulary");
    chk_attention_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_event |=> !o_host_attention_request_n)
        else $error("attention request not asserted");
    chk_tune_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_TUNE && i_param0 > TUNABLE_COUNT) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("tune index over range accepted");
    chk_compress_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && (i_cmd_code == CMD_RECORD_FOR_RECOGNITION || i_cmd_code == CMD_RECORD)
         && i_param0 > COMPRESSION_MAX) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("compression type over range accepted");
    chk_word_index: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SAY_ONE_WORD && i_param0 > i_vocab_words)
        |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("word index over range accepted");
    chk_word_count: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SAY_WORDS && i_param0 > MAX_SENTENCE_LENGTH)
        |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("word count over range accepted");
    chk_sentence_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && (i_cmd_code == CMD_SAY_SENTENCE || i_cmd_code == CMD_SAY_ARGUMENTED_SENTENCE)
         && i_param0 > i_vocab_sentences) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("sentence number over range accepted");
    chk_prompt_type: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SELECT_PROMPT_VOCABULARY
         && i_param0 != VOCAB_TYPE_EXTERNAL) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("wrong prompt type accepted");
    chk_prompt_unchanged: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SELECT_PROMPT_VOCABULARY && param_err && !prompt_r)
        |=> !prompt_r)
        else $error("refused prompt selection took effect");
    chk_topic_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && topic_cmd && !topic_ok)
        |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("topic index over range accepted");
    chk_topic_loaded: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && topic_cmd && topic_ok && i_cmd_code != CMD_TOPIC_LOAD
         && !loaded_r[i_param0[$clog2(MAX_TOPICS)-1:0]]) |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("command on unloaded topic accepted");
    chk_topic_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_TOPIC_LOAD && param_err)
        |=> (loaded_r == $past(loaded_r)))
        else $error("refused topic load changed state");
    chk_msg_play: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_PLAY && !cur_msg_r)
        |=> err_r[ERR_INVALID_BIT])
        else $error("play without current message accepted");
    chk_msg_info: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && (i_cmd_code == CMD_MESSAGE_INFO_GET || i_cmd_code == CMD_MESSAGE_INFO_SET)
         && !cur_msg_r) |=> err_r[ERR_INVALID_BIT])
        else $error("message info without current message accepted");
    chk_date_range: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SET_DATE && i_param2 < DAY_MIN)
        |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("day below range accepted");
    chk_vocab_refused: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY && param_err)
        |=> (vocab_r == $past(vocab_r)))
        else $error("vocabulary zero was accepted");
    chk_vocab_choose: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY && !param_err && !state_err)
        |=> (vocab_r == $past(i_param0)))
        else $error("active vocabulary not taken");
    chk_prompt_switch: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SELECT_PROMPT_VOCABULARY && !param_err && !state_err)
        |=> (prompt_r && vocab_r == $past(i_param1)))
        else $error("prompt vocabulary not switched");
    chk_decomp_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY && param_err)
        |=> (dec_r == $past(dec_r)))
        else $error("refused choice changed decompression");
    chk_param_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!is_read && err_r[PARAMETER_ERROR_FLAG_BIT])
        |=> err_r[PARAMETER_ERROR_FLAG_BIT])
        else $error("parameter flag lost before read");
    chk_invalid_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!is_read && err_r[ERR_INVALID_BIT])
        |=> err_r[ERR_INVALID_BIT])
        else $error("invalid flag lost before read");
    chk_error_report: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        is_read
        |=> (o_error_word == $past(err_r)))
        else $error("error word not reported on read");
    chk_attention_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!o_host_attention_request_n && !i_event && !is_read)
        |=> !o_host_attention_request_n)
        else $error("attention request dropped before read");
    chk_attention_free: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (is_read && !i_event)
        |=> o_host_attention_request_n)
        else $error("attention request not released by read");
    chk_words_no_prompt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd_code == CMD_SAY_WORDS && !prompt_r)
        |=> err_r[ERR_INVALID_BIT])
        else $error("say words without prompt vocabulary accepted");
endmodule
`default_nettype wire

/* File: hcec_host_model.sv */
// Host controller model: command issue and vocabulary storage
`timescale 1ns/1ps
`default_nettype none
module hcec_host_model
    import hcec_pkg::*;
(
    input  wire logic             i_sys_clk,
    input  wire logic [PAR_W-1:0] i_active_vocab,
    output logic                  o_cmd_valid,
    output logic [CMD_W-1:0]      o_cmd_code,
    output logic [PAR_W-1:0]      o_param0,
    output logic [PAR_W-1:0]      o_param1,
    output logic [PAR_W-1:0]      o_param2,
    output logic [PAR_W-1:0]      o_vocab_words,
    output logic [PAR_W-1:0]      o_vocab_sentences,
    output logic [CT_W-1:0]       o_vocab_compression
);
    logic [PAR_W-1:0] sel;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 5'h1F;
        {o_param0, o_param1, o_param2} = 24'hA5A5A5;
    end

    // Storage numbered from 1, each entry its own id and build rate
    always_comb begin
        sel = (o_cmd_valid && o_cmd_code == CMD_CHOOSE_ACTIVE_VOCABULARY) ? o_param0
            : i_active_vocab;
        o_vocab_words = 8'h0A * sel;
        o_vocab_sentences = 8'h02 + sel;
        o_vocab_compression = CT_W'(sel - 8'h01);
    end

    // One command per call, fields scrambled once the edge has taken them
    task automatic send(input logic [CMD_W-1:0] c, input logic [PAR_W-1:0] a, b, d);
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= c;
        {o_param0, o_param1, o_param2} <= {a, b, d};
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~c;
        {o_param0, o_param1, o_param2} <= ~{a, b, d};
    endtask
endmodule
`default_nettype wire

/* File: host_command_error_checker_test.sv */
// Self-checking testbench for the host command checker
`timescale 1ns/1ps
`default_nettype none
module host_command_error_checker_test;
    import hcec_pkg::*;
    localparam logic [7:0] OK = 8'h00, EP = 8'h08, EI = 8'h80;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_event = 1'b0;
    logic vld, done, pset, attn_n;
    logic [CMD_W-1:0] code;
    logic [PAR_W-1:0] p0, p1, p2, vw, vs, err, act;
    logic [CT_W-1:0] vc, dec;
    int fails = 0;
    int total_checks = 0;
    always #20 i_sys_clk = ~i_sys_clk;

    hcec_host_model i_host (.i_sys_clk(i_sys_clk), .i_active_vocab(act), .o_cmd_valid(vld),
        .o_cmd_code(code), .o_param0(p0), .o_param1(p1), .o_param2(p2),
        .o_vocab_words(vw), .o_vocab_sentences(vs), .o_vocab_compression(vc));
    hcec_checker #(.MAX_TOPICS(16), .VOCABS(4)) i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_cmd_valid(vld), .i_cmd_code(code), .i_param0(p0), .i_param1(p1), .i_param2(p2),
        .i_vocab_words(vw), .i_vocab_sentences(vs), .i_vocab_compression(vc),
        .i_event(i_event), .o_cmd_done(done), .o_error_word(err), .o_active_vocab(act),
        .o_prompt_set(pset), .o_decompression(dec), .o_host_attention_request_n(attn_n));

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t %s: got %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic cmd(input logic [4:0] c, input logic [7:0] a, b, d);
        i_host.send(c, a, b, d);
        #1;
        check(8'(done), 8'h01, "command done");
    endtask
    task automatic rd(input logic [7:0] want);
        cmd(CMD_READ_ERROR_WORD, OK, OK, OK);
        check(err, want, "error word");
    endtask
    task automatic stop_test;
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic t_prompt;
        cmd(CMD_SAY_SENTENCE, 8'h01, OK, OK);
        rd(EI);
        cmd(CMD_SELECT_PROMPT_VOCABULARY, 8'h02, 8'h01, OK);
        rd(EP);
        check(8'(pset), OK, "prompt kept off");
        cmd(CMD_SELECT_PROMPT_VOCABULARY, 8'h01, 8'h01, OK);
        check(8'(pset), 8'h01, "prompt set");
        rd(OK);
    endtask
    task automatic t_vocab;
        for (int n = 1; n <= 4; n++) begin
            cmd(CMD_CHOOSE_ACTIVE_VOCABULARY, 8'(n), OK, OK);
            check(8'(dec), 8'(n - 1), "decompression");
            check(act, 8'(n), "active vocabulary");
        end
        cmd(CMD_CHOOSE_ACTIVE_VOCABULARY, 8'h02, OK, OK);
        rd(OK);
    endtask
    // Vocabulary 2 active: 20 words, 4 sentences
    task automatic t_params;
        logic [4:0] c[21] = '{CMD_RECORD, CMD_RECORD, CMD_RECORD_FOR_RECOGNITION,
            CMD_SAY_WORDS, CMD_SAY_WORDS, CMD_SAY_WORDS, CMD_SAY_ONE_WORD, CMD_SAY_ONE_WORD,
            CMD_SAY_SENTENCE, CMD_SAY_SENTENCE, CMD_SAY_ARGUMENTED_SENTENCE, CMD_TUNE,
            CMD_TUNE, CMD_SET_DATE, CMD_TOPIC_LOAD, CMD_TOPIC_LOAD, CMD_TOPIC_ENABLE,
            CMD_TOPIC_ENABLE, CMD_TOPIC_SAVE, CMD_TOPIC_DISABLE, CMD_TOPIC_UNLOAD};
        int a[21] = '{3, 4, 4, 20, 21, 1, 20, 21, 4, 5, 5, 86, 87, 60, 0, 200, 0, 5, 5, 5, 5};
        int b[21] = '{0, 0, 0, 20, 1, 21, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
        bit e[21] = '{0, 1, 1, 0, 1, 1, 0, 1, 0, 1, 1, 0, 1, 1, 0, 1, 0, 1, 1, 1, 1};
        for (int i = 0; i < 21; i++) begin
            cmd(c[i], 8'(a[i]), 8'(b[i]), 8'h01);
            rd(e[i] ? EP : OK);
        end
    endtask
    task automatic t_msg;
        logic [4:0] c[7] = '{CMD_PLAY, CMD_CURRENT_MESSAGE_TAG, CMD_DELETE_MESSAGE,
            CMD_GET_MESSAGE_LENGTH, CMD_GET_MESSAGE_TYPE, CMD_MESSAGE_INFO_GET,
            CMD_MESSAGE_INFO_SET};
        foreach (c[i]) begin
            cmd(c[i], OK, OK, OK);
            rd(EI);
        end
        cmd(CMD_SELECT_MESSAGE, OK, OK, OK);
        cmd(CMD_GET_MESSAGE_LENGTH, OK, OK, OK);
        cmd(CMD_DELETE_MESSAGE, OK, OK, OK);
        rd(OK);
        cmd(CMD_GET_MESSAGE_TYPE, OK, OK, OK);
        rd(EI);
    endtask
    task automatic t_date;
        cmd(CMD_GET_TIME_DATE, OK, OK, OK);
        rd(EI);
        cmd(CMD_SET_DATE, 8'h3B, 8'h17, 8'h07);
        cmd(CMD_GET_TIME_DATE, OK, OK, OK);
        rd(OK);
        cmd(CMD_SET_DATE, OK, 8'h18, 8'h01);
        rd(EP);
    endtask
    task automatic t_rr_sticky;
        cmd(CMD_RECORD_FOR_RECOGNITION, OK, OK, OK);
        cmd(CMD_TOPIC_SAVE, OK, OK, OK);
        rd(EI);
        cmd(CMD_RECORD_FOR_RECOGNITION, 8'h03, OK, OK);
        cmd(CMD_PHONEME_EXTRACTION, OK, OK, OK);
        rd(OK);
        cmd(CMD_SAY_WORDS, 8'h15, 8'h01, OK);
        cmd(CMD_TUNE, 8'h01, OK, OK);
        rd(EP);
        rd(OK);
    endtask
    task automatic t_event;
        @(posedge i_sys_clk);
        i_event <= 1'b1;
        @(posedge i_sys_clk);
        i_event <= 1'b0;
        #1;
        check(8'(attn_n), OK, "attention low");
        rd(OK);
        @(posedge i_sys_clk);
        #1;
        check(8'(attn_n), 8'h01, "attention released");
    endtask

    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        check(err, OK, "reset error word");
        check(8'(attn_n), 8'h01, "reset attention");
        t_prompt();
        t_vocab();
        t_params();
        t_msg();
        t_date();
        t_rr_sticky();
        t_event();
        stop_test();
    end
    initial begin
        repeat (2000) @(posedge i_sys_clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
